//--- verilog/questionable_status_group.sv
// questionable status group with operation enable mask and summaries
//
// Function
// - operation enabled events drive status bit 7
// - enable masks read back written value
// - questionable summary sources status bit 3
// - condition register live, writes ignored
// - unused condition bits always read zero
// - bit 3 carries power summary
// - bit 5 carries frequency summary
// - bit 8 carries calibration summary
// - bit 9 self-test fail, reset only
// - bit 12 bit-error summary, zero without option
// - condition read returns binary weighted value
// - transition masks select which edges latch
// - absent variant bits tie to zero
// - summary is OR of enabled events
// - event read returns contents then clears
`timescale 1ns/1ps
`default_nettype none
`include "ques_status_cfg.svh"
module questionable_status_group
	import ques_status_pkg::*;
#(
	parameter bit HAS_BIT_ERROR_TEST = 1'b1 // model has the bit error test
) (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic power_sum_i,
	input wire logic freq_sum_i,
	input wire logic cal_sum_i,
	input wire logic bit_error_test_sum_i,
	input wire logic self_test_fail_i,
	input wire logic [15:0] oper_event_i,
	input wire logic clear_status_i,
	input wire logic cmd_wr_i,
	input wire logic cmd_rd_i,
	input wire logic [2:0] cmd_sel_i,
	input wire logic [15:0] cmd_wdata_i,
	output logic [15:0] rd_data_o,
	output logic rd_valid_o,
	output logic ques_summary_o,
	output logic oper_summary_o
);
	logic rst_s1_r; // reset release stage one
	logic rst_n; // synchronised reset
	logic [4:0] sync_lvl; // synchronised status inputs
	word_t cond_r; // live condition
	word_t cond_nxt;
	word_t prev_r; // condition one cycle earlier
	word_t event_r; // latched events
	word_t event_nxt;
	word_t enable_r; // questionable enable mask
	word_t ptr_r; // positive transition mask
	word_t ntr_r; // negative transition mask
	word_t oenable_r; // operation enable mask
	word_t new_ev; // filtered transitions this cycle
	logic selftest_r; // sticky self-test failure
	logic ev_read; // destructive read of the event register
	reg_sel_t sel;
	logic ques_sum_r;
	logic oper_sum_r;
	logic [15:0] rd_data_r;
	logic rd_valid_r;

	assign sel = reg_sel_t'(cmd_sel_i);
	assign ev_read = cmd_rd_i && (sel == SEL_QEVENT);

	// true when a write targets the given register
	function automatic logic wr_hit(input logic wr, input reg_sel_t s,
			input reg_sel_t want);
		wr_hit = wr && (s == want);
	endfunction

	// reset: asynchronous assert, two-flop release
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	// status inputs come from other logic on other clocks
	status_sync3 #(.WIDTH(5)) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n),
		.async_i({self_test_fail_i, bit_error_test_sum_i, cal_sum_i,
			freq_sum_i, power_sum_i}),
		.sync_o(sync_lvl)
	);

	// self-test failure sticks until reset; clear status leaves it
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			selftest_r <= 1'b0;
		end else if (sync_lvl[4]) begin
			selftest_r <= 1'b1;
		end
	end

	// assemble condition; unused and absent bits are constant zero
	always_comb begin
		cond_nxt = '0;
		cond_nxt[`QC_POWER_BIT] = sync_lvl[0];
		cond_nxt[`QC_FREQ_BIT] = sync_lvl[1];
		cond_nxt[`QC_CAL_BIT] = sync_lvl[2];
		cond_nxt[`QC_SELFTEST_BIT] = selftest_r;
		// tied off in models without the test capability
		cond_nxt[`QC_BIT_ERROR_TEST_BIT] = sync_lvl[3] & HAS_BIT_ERROR_TEST;
		cond_nxt = cond_nxt & `QC_USED_MASK;
	end

	// condition follows inputs only; writes never reach it
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			cond_r <= '0;
			prev_r <= '0;
		end else begin
			cond_r <= cond_nxt;
			prev_r <= cond_r;
		end
	end

	// edge filters pick rising and falling changes per bit
	assign new_ev = (cond_r & ~prev_r & ptr_r)
		| (~cond_r & prev_r & ntr_r);

	// a new event in the clearing cycle survives the clear
	always_comb begin
		event_nxt = event_r;
		if (ev_read || clear_status_i) begin
			event_nxt = '0;
		end
		event_nxt = event_nxt | new_ev;
	end

	// event register
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			event_r <= `RST_EVENT;
		end else begin
			event_r <= event_nxt;
		end
	end

	// writable masks hold exactly the written word
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			enable_r <= `RST_ENABLE;
			ptr_r <= `RST_PTR;
			ntr_r <= `RST_NTR;
			oenable_r <= `RST_ENABLE;
		end else begin
			if (wr_hit(cmd_wr_i, sel, SEL_QENABLE)) begin
				enable_r <= cmd_wdata_i;
			end
			if (wr_hit(cmd_wr_i, sel, SEL_QPTR)) begin
				ptr_r <= cmd_wdata_i;
			end
			if (wr_hit(cmd_wr_i, sel, SEL_QNTR)) begin
				ntr_r <= cmd_wdata_i;
			end
			if (wr_hit(cmd_wr_i, sel, SEL_OENABLE)) begin
				oenable_r <= cmd_wdata_i;
			end
		end
	end

	// read port: data registered one cycle after the strobe
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_r <= '0;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= cmd_rd_i;
			if (cmd_rd_i) begin
				unique case (sel)
					SEL_QCOND: rd_data_r <= cond_r;
					SEL_QEVENT: rd_data_r <= event_r;
					SEL_QENABLE: rd_data_r <= enable_r;
					SEL_QPTR: rd_data_r <= ptr_r;
					SEL_QNTR: rd_data_r <= ntr_r;
					SEL_OENABLE: rd_data_r <= oenable_r;
					default: rd_data_r <= '0; // unmapped code
				endcase
			end
		end
	end

	// summaries; one cycle behind the event state
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			ques_sum_r <= 1'b0;
			oper_sum_r <= 1'b0;
		end else begin
			ques_sum_r <= |(event_r & enable_r);
			oper_sum_r <= |(oper_event_i & oenable_r);
		end
	end

	assign rd_data_o = rd_data_r;
	assign rd_valid_o = rd_valid_r;
	assign ques_summary_o = ques_sum_r;
	assign oper_summary_o = oper_sum_r;

	a_unused_zero: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		(cond_r & ~(`QC_USED_MASK)) == 16'h0000)
		else $error("unused condition bit set");
	a_selftest_sticky: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		cond_r[`QC_SELFTEST_BIT] |=> cond_r[`QC_SELFTEST_BIT] [*3])
		else $error("self-test bit dropped");
	a_bit_error_test_tied: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		!HAS_BIT_ERROR_TEST |-> !cond_r[`QC_BIT_ERROR_TEST_BIT])
		else $error("bit error bit set without option");
	a_ques_summary: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		##1 ques_summary_o == |($past(event_r) & $past(enable_r)))
		else $error("questionable summary wrong");
	a_oper_summary: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		##1 oper_summary_o == |($past(oper_event_i) & $past(oenable_r)))
		else $error("operation summary wrong");
	a_enable_readback: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		(cmd_wr_i && sel == SEL_QENABLE && !cmd_rd_i)
		##1 (cmd_rd_i && !cmd_wr_i && sel == SEL_QENABLE)
		|=> rd_data_o == $past(cmd_wdata_i, 2))
		else $error("enable readback mismatch");
	a_event_clear: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		(ev_read && new_ev == 16'h0000) |=> event_r == 16'h0000)
		else $error("event not cleared by read");
	a_edge_latch: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		(new_ev != 16'h0000) |=> (event_r & $past(new_ev)) == $past(new_ev))
		else $error("filtered transition lost");
	a_cond_read: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		(cmd_rd_i && sel == SEL_QCOND) |=> rd_data_o == $past(cond_r))
		else $error("condition read wrong");
endmodule
`default_nettype wire

//--- pkg/ques_status_cfg.svh
// constants for the questionable status group: selectors, fields, resets
`ifndef QUES_STATUS_CFG_SVH
`define QUES_STATUS_CFG_SVH

// register selector codes on the command port
`define SEL_QUES_COND 3'h0
`define SEL_QUES_EVENT 3'h1
`define SEL_QUES_ENABLE 3'h2
`define SEL_QUES_PTR 3'h3
`define SEL_QUES_NTR 3'h4
`define SEL_OPER_ENABLE 3'h5

// condition bit positions
`define QC_POWER_BIT 3
`define QC_FREQ_BIT 5
`define QC_CAL_BIT 8
`define QC_SELFTEST_BIT 9
`define QC_BIT_ERROR_TEST_BIT 12

// bits that may ever be set; all others read as zero
`define QC_USED_MASK 16'h1328

// reset values
`define RST_EVENT 16'h0000
`define RST_ENABLE 16'h0000
`define RST_PTR 16'hFFFF
`define RST_NTR 16'h0000

`endif

//--- pkg/ques_status_pkg.sv
// types shared by the questionable status group
`include "ques_status_cfg.svh"
package ques_status_pkg;
	// register selected by a command
	typedef enum logic [2:0] {
		SEL_QCOND = `SEL_QUES_COND,
		SEL_QEVENT = `SEL_QUES_EVENT,
		SEL_QENABLE = `SEL_QUES_ENABLE,
		SEL_QPTR = `SEL_QUES_PTR,
		SEL_QNTR = `SEL_QUES_NTR,
		SEL_OENABLE = `SEL_OPER_ENABLE
	} reg_sel_t;
	typedef logic [15:0] word_t; // one status register
endpackage

//--- verilog/status_sync3.sv
// three-stage synchroniser with agreement filter for status inputs
`timescale 1ns/1ps
`default_nettype none
module status_sync3 #(
	parameter int WIDTH = 4
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] s1_r; // first stage, read only by s2_r
	logic [WIDTH-1:0] s2_r; // second stage
	logic [WIDTH-1:0] s3_r; // third stage
	logic [WIDTH-1:0] out_r; // filtered level

	// shift chain; metastability settles in the first stage
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= async_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// a bit changes only once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_filt
			always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					out_r[g] <= 1'b0;
				end else if (s2_r[g] == s3_r[g]) begin
					out_r[g] <= s3_r[g];
				end
			end
		end
	endgenerate

	assign sync_o = out_r;
endmodule
`default_nettype wire

//--- test/tb_questionable_status_group.sv
// self-checking bench for the questionable status group command port
`timescale 1ns/1ps
`default_nettype none
module tb_questionable_status_group
	import ques_status_pkg::*;
;
	logic clk_sys_i = 1'b0; // 125 MHz system clock
	logic arst_n_i = 1'b0; // async reset, low active
	logic power_sum_i = 1'b0; // sub-group summaries
	logic freq_sum_i = 1'b0;
	logic cal_sum_i = 1'b0;
	logic bit_error_test_sum_i = 1'b0;
	logic self_test_fail_i = 1'b0;
	logic [15:0] oper_event_i = 16'h0000; // operation events
	logic clear_status_i = 1'b0;
	logic cmd_wr_i = 1'b0;
	logic cmd_rd_i = 1'b0;
	logic [2:0] cmd_sel_i = 3'h0;
	logic [15:0] cmd_wdata_i = 16'h0000;
	logic [15:0] rd_data_o;
	logic rd_valid_o;
	logic ques_summary_o;
	logic oper_summary_o;
	logic [15:0] rd_data_nb; // read data of the variant without the test
	int err_total = 0; // mismatches seen
	int n_compared = 0; // comparisons made
	questionable_status_group #(.HAS_BIT_ERROR_TEST(1'b1)) uut (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.power_sum_i(power_sum_i),
		.freq_sum_i(freq_sum_i),
		.cal_sum_i(cal_sum_i),
		.bit_error_test_sum_i(bit_error_test_sum_i),
		.self_test_fail_i(self_test_fail_i),
		.oper_event_i(oper_event_i),
		.clear_status_i(clear_status_i),
		.cmd_wr_i(cmd_wr_i),
		.cmd_rd_i(cmd_rd_i),
		.cmd_sel_i(cmd_sel_i),
		.cmd_wdata_i(cmd_wdata_i),
		.rd_data_o(rd_data_o),
		.rd_valid_o(rd_valid_o),
		.ques_summary_o(ques_summary_o),
		.oper_summary_o(oper_summary_o)
	);
	// variant without the bit error test; shares every input with uut
	questionable_status_group #(.HAS_BIT_ERROR_TEST(1'b0)) uut_nobert (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.power_sum_i(power_sum_i),
		.freq_sum_i(freq_sum_i),
		.cal_sum_i(cal_sum_i),
		.bit_error_test_sum_i(bit_error_test_sum_i),
		.self_test_fail_i(self_test_fail_i),
		.oper_event_i(oper_event_i),
		.clear_status_i(clear_status_i),
		.cmd_wr_i(cmd_wr_i),
		.cmd_rd_i(cmd_rd_i),
		.cmd_sel_i(cmd_sel_i),
		.cmd_wdata_i(cmd_wdata_i),
		.rd_data_o(rd_data_nb),
		.rd_valid_o(),
		.ques_summary_o(),
		.oper_summary_o()
	);
	// free-running clock, 8 ns period
	initial begin
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	// verdict and end of run
	task automatic end_of_test();
		if (err_total == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// compare a read word
	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
		end
	endtask
	// compare a one-bit level: a summary or the read valid flag
	task automatic cmp_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t summary %b expected %b", $time, got, exp);
		end
	endtask
	// one-cycle write strobe, no answer expected
	task automatic wr(input logic [2:0] sel, input logic [15:0] data);
		@(negedge clk_sys_i);
		cmd_wr_i = 1'b1;
		cmd_sel_i = sel;
		cmd_wdata_i = data;
		@(negedge clk_sys_i);
		cmd_wr_i = 1'b0;
	endtask
	// one-cycle read strobe, then a bounded wait for the valid pulse
	task automatic rd(input logic [2:0] sel, input logic [15:0] exp);
		int i;
		@(negedge clk_sys_i);
		cmd_rd_i = 1'b1;
		cmd_sel_i = sel;
		@(negedge clk_sys_i);
		cmd_rd_i = 1'b0;
		for (i = 0; i < 4 && rd_valid_o !== 1'b1; i++) begin
			@(negedge clk_sys_i);
		end
		if (rd_valid_o !== 1'b1) begin
			err_total++;
			$display("CHECK FAILED %0t no read answer", $time);
			end_of_test();
		end else begin
			cmp_word(rd_data_o, exp);
		end
	endtask
	// status inputs need about seven edges to reach the summary
	task automatic settle();
		repeat (10) @(negedge clk_sys_i);
	endtask
	// main sequence
	initial begin
		repeat (10) @(negedge clk_sys_i);
		arst_n_i = 1'b1;
		repeat (3) @(negedge clk_sys_i);
		rd(SEL_QPTR, 16'hFFFF);
		rd(SEL_QNTR, 16'h0000);
		rd(SEL_QENABLE, 16'h0000);
		rd(SEL_OENABLE, 16'h0000);
		rd(SEL_QEVENT, 16'h0000);
		wr(SEL_QCOND, 16'hFFFF);
		rd(SEL_QCOND, 16'h0000);
		// raise every summary input at once; unused bits must stay zero
		power_sum_i = 1'b1;
		freq_sum_i = 1'b1;
		cal_sum_i = 1'b1;
		bit_error_test_sum_i = 1'b1;
		self_test_fail_i = 1'b1;
		settle();
		rd(SEL_QCOND, 16'h1328);
		cmp_word(rd_data_nb, 16'h0328);
		cmp_bit(ques_summary_o, 1'b0);
		// back-to-back write then read of the enable mask
		@(negedge clk_sys_i);
		cmd_wr_i = 1'b1;
		cmd_sel_i = SEL_QENABLE;
		cmd_wdata_i = 16'h0208;
		@(negedge clk_sys_i);
		cmd_wr_i = 1'b0;
		cmd_rd_i = 1'b1;
		@(negedge clk_sys_i);
		cmd_rd_i = 1'b0;
		cmp_bit(rd_valid_o, 1'b1);
		cmp_word(rd_data_o, 16'h0208);
		repeat (3) @(negedge clk_sys_i);
		cmp_bit(ques_summary_o, 1'b1);
		rd(SEL_QEVENT, 16'h1328);
		rd(SEL_QEVENT, 16'h0000);
		repeat (3) @(negedge clk_sys_i);
		cmp_bit(ques_summary_o, 1'b0);
		// swap the filters: only falling conditions latch now
		wr(SEL_QPTR, 16'h0000);
		wr(SEL_QNTR, 16'hFFFF);
		rd(SEL_QNTR, 16'hFFFF);
		power_sum_i = 1'b0;
		settle();
		rd(SEL_QEVENT, 16'h0008);
		power_sum_i = 1'b1;
		settle();
		rd(SEL_QEVENT, 16'h0000);
		// clear-status drops events but keeps the self-test bit
		freq_sum_i = 1'b0;
		self_test_fail_i = 1'b0;
		settle();
		clear_status_i = 1'b1;
		@(negedge clk_sys_i);
		clear_status_i = 1'b0;
		rd(SEL_QEVENT, 16'h0000);
		rd(SEL_QCOND, 16'h1308);
		// operation group summary
		oper_event_i = 16'h0028;
		wr(SEL_OENABLE, 16'h0008);
		rd(SEL_OENABLE, 16'h0008);
		cmp_bit(oper_summary_o, 1'b1);
		oper_event_i = 16'h0010;
		repeat (2) @(negedge clk_sys_i);
		cmp_bit(oper_summary_o, 1'b0);
		wr(SEL_OENABLE, 16'hFFFF);
		repeat (2) @(negedge clk_sys_i);
		cmp_bit(oper_summary_o, 1'b1);
		// unmapped selector reads zero, write is ignored
		wr(3'h7, 16'hFFFF);
		rd(3'h6, 16'h0000);
		// the event register cannot be written
		wr(SEL_QEVENT, 16'hFFFF);
		rd(SEL_QEVENT, 16'h0000);
		// second reset in mid-run restores the filter and mask values
		arst_n_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		arst_n_i = 1'b1;
		repeat (3) @(negedge clk_sys_i);
		rd(SEL_QPTR, 16'hFFFF);
		rd(SEL_OENABLE, 16'h0000);
		end_of_test();
	end
endmodule
`default_nettype wire
